// >>> rtl/aicp_checksum.sv
`timescale 1ns/1ps
`default_nettype none
module aicp_checksum
  import aicp_pkg::*;
(
  input wire logic sys_clk_in,
  input wire logic rstn_in,
  input wire logic ce_in,
  input wire aicp_wr_type wr_in,
  output logic [7:0] crc_out,
  output logic [7:0] xor_out
);
  logic is_sel;
  logic [7:0] crc_nxt;
  logic [7:0] crc_r;
  logic [7:0] xor_r;

  assign is_sel = (wr_in.addr == AICP_OFS_PAGE) ||
                  (wr_in.page == 8'h00 && wr_in.addr == AICP_OFS_BOOK);

  always_comb begin
    crc_nxt = crc_r ^ wr_in.data;
    for (int i = 0; i < 8; i++) begin
      crc_nxt = crc_nxt[7] ? ((crc_nxt << 1) ^ AICP_CRC_POLY) : (crc_nxt << 1);
    end
  end

  always_ff @(posedge sys_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      crc_r <= 8'h00;
    end else if (ce_in && wr_in.wr) begin
      if (wr_in.page == 8'h00 && wr_in.addr == AICP_OFS_CRC && wr_in.data == 8'h00) begin
        crc_r <= 8'h00;
      end else if (!is_sel) begin
        crc_r <= crc_nxt;
      end
    end
  end

  always_ff @(posedge sys_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      xor_r <= 8'h00;
    end else if (ce_in && wr_in.wr && wr_in.book == AICP_XOR_BOOK) begin
      if (wr_in.page == 8'h00 && wr_in.addr == AICP_OFS_XOR && wr_in.data == 8'h00) begin
        xor_r <= 8'h00;
      end else if (wr_in.page != 8'h00 && wr_in.addr != AICP_OFS_PAGE) begin
        xor_r <= xor_r ^ wr_in.data;
      end
    end
  end

  assign crc_out = crc_r;
  assign xor_out = xor_r;
endmodule // aicp_checksum
`default_nettype wire

// >>> rtl/aicp_pkg.sv
package aicp_pkg;
  localparam logic [3:0] AICP_ADDR_HI = 4'hc;
  localparam logic [2:0] AICP_STRAP_MAX = 3'h5;
  localparam logic [7:0] AICP_OFS_PAGE = 8'h00;
  localparam logic [7:0] AICP_OFS_STATE = 8'h03;
  localparam logic [7:0] AICP_OFS_XOR = 8'h7d;
  localparam logic [7:0] AICP_OFS_CRC = 8'h7e;
  localparam logic [7:0] AICP_OFS_BOOK = 8'h7f;
  localparam logic [7:0] AICP_RST_STATE = 8'h10;
  localparam logic [7:0] AICP_XOR_BOOK = 8'h8c;
  localparam logic [7:0] AICP_COEF_BOOK = 8'haa;
  localparam logic [7:0] AICP_CRC_POLY = 8'h07;
  localparam logic [1:0] AICP_STATE_HIZ = 2'h2;

  typedef struct packed {
    logic wr;
    logic [7:0] book;
    logic [7:0] page;
    logic [7:0] addr;
    logic [7:0] data;
  } aicp_wr_type;
endpackage

// >>> rtl/aicp_top.sv
`timescale 1ns/1ps
`default_nettype none
module aicp_top
  import aicp_pkg::*;
(
  input wire logic sys_clk_in,
  input wire logic rstn_in,
  input wire logic ce_in,
  input wire logic [2:0] strap_in,
  input wire logic power_down_pin_in,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_oe_out,
  output logic sda_o_out,
  output logic [1:0] dev_state_out,
  output logic [7:0] book_out,
  output logic [7:0] page_out
);
  // ---------------------------------------------------------------
  // Pin synchronisers
  // ---------------------------------------------------------------
  logic [1:0] scl_s_r;
  logic [1:0] sda_s_r;
  logic [1:0] pdn_s_r;
  logic scl_d_r;
  logic sda_d_r;

  always_ff @(posedge sys_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      scl_s_r <= 2'h3;
      sda_s_r <= 2'h3;
      pdn_s_r <= 2'h0;
      scl_d_r <= 1'b1;
      sda_d_r <= 1'b1;
    end else if (ce_in) begin
      scl_s_r <= {scl_s_r[0], scl_in};
      sda_s_r <= {sda_s_r[0], sda_in};
      pdn_s_r <= {pdn_s_r[0], power_down_pin_in};
      scl_d_r <= scl_s_r[1];
      sda_d_r <= sda_s_r[1];
    end
  end

  logic scl_rise;
  logic scl_fall;
  logic start_det;
  logic stop_det;
  logic run;
  assign scl_rise = scl_s_r[1] && !scl_d_r;
  assign scl_fall = !scl_s_r[1] && scl_d_r;
  assign start_det = scl_s_r[1] && scl_d_r && sda_d_r && !sda_s_r[1];
  assign stop_det = scl_s_r[1] && scl_d_r && !sda_d_r && sda_s_r[1];
  // The bus logic and the page, book and state registers are held in reset while the power-down pin is low and ce_in is high.
  assign run = ce_in && pdn_s_r[1];

  // ---------------------------------------------------------------
  // Bus state machine
  // ---------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_IDLE, ST_ADDR, ST_ADDR_ACK, ST_SUB, ST_SUB_ACK, ST_WDATA, ST_WDATA_ACK, ST_RDATA
  } aicp_st_type;
  typedef enum logic [1:0] {R_NONE, R_BYTE, R_ACK} aicp_rph_type;

  aicp_st_type st_r;
  aicp_rph_type rph_r;
  logic [2:0] bit_r;
  logic [7:0] sh_r;
  logic [7:0] sub_r;
  logic rw_r;
  logic ack_drv_r;
  logic [7:0] tx_r;
  logic [7:0] rdata;
  logic [7:0] byte_in;
  logic addr_hit;

  assign byte_in = {sh_r[6:0], sda_s_r[1]};
  assign addr_hit = (byte_in[7:4] == AICP_ADDR_HI) && (byte_in[3:1] == strap_in) &&
                    (strap_in <= AICP_STRAP_MAX);

  logic [7:0] book_r;
  logic [7:0] page_r;
  logic [7:0] state_r;
  logic [7:0] crc_val;
  logic [7:0] xor_val;
  aicp_wr_type wr_r;

  always_comb begin
    rdata = 8'h00;
    if (sub_r == AICP_OFS_PAGE) begin
      rdata = page_r;
    end else if (page_r == 8'h00) begin
      unique case (sub_r)
        AICP_OFS_STATE: rdata = state_r;
        AICP_OFS_CRC: rdata = crc_val;
        AICP_OFS_XOR: rdata = (book_r == AICP_XOR_BOOK) ? xor_val : 8'h00;
        AICP_OFS_BOOK: rdata = book_r;
        default: rdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge sys_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      st_r <= ST_IDLE;
      rph_r <= R_NONE;
      bit_r <= 3'h0;
      sh_r <= 8'h00;
      sub_r <= 8'h00;
      rw_r <= 1'b0;
      ack_drv_r <= 1'b0;
      tx_r <= 8'h00;
      wr_r <= '0;
    end else if (ce_in && !pdn_s_r[1]) begin
      st_r <= ST_IDLE;
      ack_drv_r <= 1'b0;
      rph_r <= R_NONE;
      wr_r <= '0;
    end else if (run) begin
      wr_r.wr <= 1'b0;
      if (start_det) begin
        st_r <= ST_ADDR;
        bit_r <= 3'h0;
        ack_drv_r <= 1'b0;
        rph_r <= R_NONE;
      end else if (stop_det) begin
        st_r <= ST_IDLE;
        ack_drv_r <= 1'b0;
        rph_r <= R_NONE;
      end else begin
        unique case (st_r)
          ST_IDLE: ;
          ST_ADDR, ST_SUB, ST_WDATA: begin
            if (scl_rise) begin
              sh_r <= byte_in;
              bit_r <= bit_r + 3'h1;
              if (bit_r == 3'h7) begin
                if (st_r == ST_ADDR) begin
                  if (addr_hit) begin
                    rw_r <= byte_in[0];
                    st_r <= ST_ADDR_ACK;
                  end else begin
                    st_r <= ST_IDLE;
                  end
                end else if (st_r == ST_SUB) begin
                  sub_r <= byte_in;
                  st_r <= ST_SUB_ACK;
                end else begin
                  wr_r <= '{wr: 1'b1, book: book_r, page: page_r, addr: sub_r, data: byte_in};
                  st_r <= ST_WDATA_ACK;
                end
              end
            end
          end
          ST_ADDR_ACK, ST_SUB_ACK, ST_WDATA_ACK: begin
            if (scl_fall) begin
              if (!ack_drv_r) begin
                ack_drv_r <= 1'b1;
              end else begin
                ack_drv_r <= 1'b0;
                bit_r <= 3'h0;
                if (st_r == ST_ADDR_ACK && rw_r) begin
                  st_r <= ST_RDATA;
                  rph_r <= R_BYTE;
                  tx_r <= rdata;
                  ack_drv_r <= 1'b0;
                end else if (st_r == ST_ADDR_ACK) begin
                  st_r <= ST_SUB;
                end else begin
                  if (st_r == ST_WDATA_ACK) begin
                    sub_r <= sub_r + 8'h01;
                  end
                  st_r <= ST_WDATA;
                end
              end
            end
          end
          ST_RDATA: begin
            unique case (rph_r)
              R_BYTE: begin
                if (scl_fall) begin
                  bit_r <= bit_r + 3'h1;
                  tx_r <= {tx_r[6:0], 1'b0};
                  if (bit_r == 3'h7) begin
                    rph_r <= R_ACK;
                  end
                end
              end
              R_ACK: begin
                if (scl_rise) begin
                  if (sda_s_r[1]) begin
                    st_r <= ST_IDLE;
                    rph_r <= R_NONE;
                  end else begin
                    sub_r <= sub_r + 8'h01;
                    rph_r <= R_NONE;
                  end
                end
              end
              R_NONE: begin
                if (scl_fall) begin
                  rph_r <= R_BYTE;
                  bit_r <= 3'h0;
                  tx_r <= rdata;
                end
              end
              default: rph_r <= R_NONE;
            endcase
          end
          default: st_r <= ST_IDLE;
        endcase
      end
    end
  end

  // ---------------------------------------------------------------
  // SDA drive, open drain: enable high pulls the line low
  // ---------------------------------------------------------------
  logic rbit;
  logic sda_oe_r;
  always_comb begin
    rbit = 1'b1;
    if (st_r == ST_RDATA && rph_r == R_BYTE) begin
      rbit = (bit_r == 3'h0) ? rdata[7] : tx_r[7];
    end
  end
  // The first bit of a byte is taken straight from the read mux.
  always_ff @(posedge sys_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      sda_oe_r <= 1'b0;
    end else if (ce_in) begin
      sda_oe_r <= ack_drv_r || !rbit;
    end
  end
  assign sda_oe_out = sda_oe_r;
  assign sda_o_out = 1'b0;

  // ---------------------------------------------------------------
  // Registers: page, book, device state
  // ---------------------------------------------------------------
  always_ff @(posedge sys_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      page_r <= 8'h00;
      book_r <= 8'h00;
      state_r <= AICP_RST_STATE;
    end else if (ce_in && !pdn_s_r[1]) begin
      page_r <= 8'h00;
      book_r <= 8'h00;
      state_r <= AICP_RST_STATE;
    end else if (ce_in && wr_r.wr) begin
      if (wr_r.addr == AICP_OFS_PAGE) begin
        page_r <= wr_r.data;
      end else if (wr_r.page == 8'h00 && wr_r.addr == AICP_OFS_BOOK) begin
        book_r <= wr_r.data;
      end else if (wr_r.page == 8'h00 && wr_r.addr == AICP_OFS_STATE) begin
        state_r <= wr_r.data;
      end
    end
  end

  aicp_checksum u_sum (
    .sys_clk_in(sys_clk_in),
    .rstn_in(rstn_in),
    .ce_in(ce_in),
    .wr_in(wr_r),
    .crc_out(crc_val),
    .xor_out(xor_val)
  );

  logic [1:0] dev_state_r;
  always_ff @(posedge sys_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      dev_state_r <= AICP_STATE_HIZ;
    end else if (ce_in) begin
      dev_state_r <= pdn_s_r[1] ? state_r[1:0] : AICP_STATE_HIZ;
    end
  end
  assign dev_state_out = dev_state_r;
  assign book_out = book_r;
  assign page_out = page_r;

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  AST_PAGE_WR: assert property (@(posedge sys_clk_in) disable iff (!rstn_in)
    (ce_in && pdn_s_r[1] && wr_r.wr && wr_r.addr == AICP_OFS_PAGE) |=> page_r == $past(wr_r.data))
    else $error("page select not taken");
  AST_BOOK_WR: assert property (@(posedge sys_clk_in) disable iff (!rstn_in)
    (ce_in && pdn_s_r[1] && wr_r.wr && wr_r.page == 8'h00 && wr_r.addr == AICP_OFS_BOOK)
    |=> book_r == $past(wr_r.data))
    else $error("book select not taken");
  AST_RD_STABLE: assert property (@(posedge sys_clk_in) disable iff (!rstn_in)
    (ce_in && st_r == ST_RDATA && !wr_r.wr) |=> $stable(crc_val) && $stable(xor_val))
    else $error("checksum moved without write");
  AST_ADDR_NOHIT: assert property (@(posedge sys_clk_in) disable iff (!rstn_in)
    (run && !start_det && !stop_det && st_r == ST_ADDR && scl_rise && bit_r == 3'h7 && !addr_hit)
    |=> st_r == ST_IDLE)
    else $error("foreign address accepted");
  AST_SUB_INC: assert property (@(posedge sys_clk_in) disable iff (!rstn_in)
    (run && !start_det && !stop_det && st_r == ST_WDATA_ACK && scl_fall && ack_drv_r)
    |=> sub_r == $past(sub_r) + 8'h01)
    else $error("subaddress not advanced");
  AST_ACK_DRIVE: assert property (@(posedge sys_clk_in) disable iff (!rstn_in)
    (ack_drv_r && ce_in) |=> sda_oe_r)
    else $error("ack not driven");
  AST_CRC_CLR: assert property (@(posedge sys_clk_in) disable iff (!rstn_in)
    (ce_in && wr_r.wr && wr_r.page == 8'h00 && wr_r.addr == AICP_OFS_CRC && wr_r.data == 8'h00)
    |=> crc_val == 8'h00)
    else $error("crc not cleared");
  AST_RD_INC: assert property (@(posedge sys_clk_in) disable iff (!rstn_in)
    (run && !start_det && !stop_det && st_r == ST_RDATA && rph_r == R_ACK && scl_rise &&
     !sda_s_r[1]) |=> sub_r == $past(sub_r) + 8'h01)
    else $error("read subaddress not advanced");

  // ---------------------------------------------------------------
  // Checksum, read load and line checks
  // ---------------------------------------------------------------
  AST_CRC_SEL_HOLD: assert property (@(posedge sys_clk_in) disable iff (!rstn_in)
    (ce_in && wr_r.wr && wr_r.addr == AICP_OFS_PAGE) |=> $stable(crc_val))
    else $error("crc moved on page switch");
  AST_XOR_BOOK: assert property (@(posedge sys_clk_in) disable iff (!rstn_in)
    (ce_in && wr_r.wr && wr_r.book != AICP_XOR_BOOK) |=> $stable(xor_val))
    else $error("xor moved outside its book");
  AST_XOR_CLR: assert property (@(posedge sys_clk_in) disable iff (!rstn_in)
    (ce_in && wr_r.wr && wr_r.book == AICP_XOR_BOOK && wr_r.page == 8'h00 &&
     wr_r.addr == AICP_OFS_XOR && wr_r.data == 8'h00) |=> xor_val == 8'h00)
    else $error("xor not cleared");
  AST_RD_LOAD: assert property (@(posedge sys_clk_in) disable iff (!rstn_in)
    (run && !start_det && !stop_det && st_r == ST_ADDR_ACK && rw_r && scl_fall && ack_drv_r)
    |=> st_r == ST_RDATA && tx_r == $past(rdata))
    else $error("read byte not loaded");
  AST_RD_RELEASE: assert property (@(posedge sys_clk_in) disable iff (!rstn_in)
    (ce_in && st_r == ST_RDATA && rph_r == R_ACK && !ack_drv_r) |=> !sda_oe_r)
    else $error("line held during controller ack");
  AST_IDLE_QUIET: assert property (@(posedge sys_clk_in) disable iff (!rstn_in)
    (ce_in && st_r == ST_IDLE && !ack_drv_r) |=> !sda_oe_r)
    else $error("line driven while idle");
  COV_WRITE: cover property (@(posedge sys_clk_in) wr_r.wr);
  COV_READ: cover property (@(posedge sys_clk_in) st_r == ST_RDATA && rph_r == R_ACK);
  COV_BOOK: cover property (@(posedge sys_clk_in) book_r == AICP_XOR_BOOK);
  COV_NOHIT: cover property (@(posedge sys_clk_in) st_r == ST_ADDR && scl_rise && bit_r == 3'h7 && !addr_hit);
endmodule // aicp_top
`default_nettype wire

// >>> verif/aicp_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module aicp_host_model #(
  parameter int HALF = 20
) (
  input wire logic sys_clk_in,
  input wire logic sda_in,
  output logic scl_out,
  output logic sda_out
);
  // ------------------------------------------------------------------
  // Bus controller: releasing SDA lets the pull-up take the line high.
  // ------------------------------------------------------------------
  initial begin
    scl_out = 1'b1;
    sda_out = 1'b1;
  end

  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk_in);
  endtask

  // SDA moves only in mid-low so that no false start or stop is seen.
  task automatic xbit(input logic b, output logic r);
    tick(HALF / 2);
    sda_out <= b;
    tick(HALF / 2);
    scl_out <= 1'b1;
    tick(HALF / 2);
    r = sda_in;
    tick(HALF / 2);
    scl_out <= 1'b0;
  endtask

  task automatic start;
    tick(HALF / 2);
    sda_out <= 1'b1;
    tick(HALF / 2);
    scl_out <= 1'b1;
    tick(HALF / 2);
    sda_out <= 1'b0;
    tick(HALF / 2);
    scl_out <= 1'b0;
  endtask

  task automatic stop;
    tick(HALF / 2);
    sda_out <= 1'b0;
    tick(HALF / 2);
    scl_out <= 1'b1;
    tick(HALF / 2);
    sda_out <= 1'b1;
    tick(HALF);
  endtask

  task automatic put(input logic [7:0] b, inout logic ok);
    logic r;
    for (int i = 7; i >= 0; i--) xbit(b[i], r);
    xbit(1'b1, r);
    ok = ok & ~r;
  endtask

  task automatic get(input logic last, output logic [7:0] q);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      xbit(1'b1, r);
      q[i] = r;
    end
    xbit(last, r);
  endtask

  task automatic wr(input logic [6:0] adr, input logic [7:0] sub, input logic [7:0] d [5],
                    input int n, output logic ok);
    ok = 1'b1;
    start();
    put({adr, 1'b0}, ok);
    put(sub, ok);
    for (int k = 0; k < n; k++) put(d[k], ok);
    stop();
  endtask

  task automatic rd(input logic [6:0] adr, input logic [7:0] sub, input int n,
                    output logic [7:0] q [4], output logic ok);
    ok = 1'b1;
    start();
    put({adr, 1'b0}, ok);
    put(sub, ok);
    start();
    put({adr, 1'b1}, ok);
    for (int k = 0; k < n; k++) get(k == n - 1, q[k]);
    stop();
  endtask
endmodule // aicp_host_model
`default_nettype wire

// >>> verif/tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
  import aicp_pkg::*;
  typedef struct {
    logic [7:0] sub;
    logic [7:0] wd;
    logic [7:0] rd;
  } aicp_row_type;
  localparam logic [6:0] ADR = {AICP_ADDR_HI, 3'h3};
  logic sys_clk = 1'b0;
  logic rstn = 1'b0;
  logic power_down_pin = 1'b0;
  logic ce = 1'b1;
  logic sda_o;
  logic [2:0] strap = 3'h3;
  logic scl;
  logic host_sda;
  logic sda_line;
  logic sda_oe;
  logic [1:0] dev_state;
  logic [7:0] book;
  logic [7:0] page;
  logic ok;
  logic [7:0] q [4];
  logic [7:0] c;
  int num_errors = 0;
  int check_count = 0;
  aicp_row_type rows [5] = '{'{8'h03, 8'h12, 8'h12}, '{8'h00, 8'h05, 8'h05},
    '{8'h00, 8'h00, 8'h00}, '{8'h40, 8'h5a, 8'h00}, '{8'h7d, 8'h33, 8'h00}};

  always #25 sys_clk = ~sys_clk;
  assign sda_line = host_sda & (sda_oe ? sda_o : 1'b1);

  aicp_top dut_u (.sys_clk_in(sys_clk), .rstn_in(rstn), .ce_in(ce), .strap_in(strap),
    .power_down_pin_in(power_down_pin), .scl_in(scl), .sda_in(sda_line),
    .sda_oe_out(sda_oe), .sda_o_out(sda_o), .dev_state_out(dev_state), .book_out(book),
    .page_out(page));
  aicp_host_model host_u (.sys_clk_in(sys_clk), .sda_in(sda_line), .scl_out(scl),
    .sda_out(host_sda));

  // ------------------------------------------------------------------
  // Checking helpers.
  // ------------------------------------------------------------------
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp) begin
      num_errors++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic w_n(input logic [7:0] sub, input logic [7:0] d [5], input int n);
    host_u.wr(ADR, sub, d, n, ok);
    chk({7'h0, ok}, 8'h01);
  endtask

  task automatic r_n(input logic [7:0] sub, input int n);
    host_u.rd(ADR, sub, n, q, ok);
    chk({7'h0, ok}, 8'h01);
  endtask

  function automatic logic [7:0] crc8(input logic [7:0] cv, input logic [7:0] b);
    logic [7:0] x;
    x = cv ^ b;
    for (int i = 0; i < 8; i++) x = x[7] ? ({x[6:0], 1'b0} ^ AICP_CRC_POLY) : {x[6:0], 1'b0};
    return x;
  endfunction

  task automatic finish_test;
    $display("checks %0d errors %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  initial begin
    repeat (100000) @(posedge sys_clk);
    num_errors++;
    $display("[ERR] %0t run limit reached", $time);
    finish_test();
  end

  // ------------------------------------------------------------------
  // Main sequence.
  // ------------------------------------------------------------------
  initial begin
    repeat (5) @(posedge sys_clk);
    rstn <= 1'b1;
    repeat (10) @(posedge sys_clk);
    power_down_pin <= 1'b1;
    repeat (8) @(posedge sys_clk);
    chk({6'h0, dev_state}, {6'h0, AICP_RST_STATE[1:0]});
    chk(book, 8'h00);
    chk(page, 8'h00);
    r_n(AICP_OFS_STATE, 1);
    chk(q[0], AICP_RST_STATE);
    $display("test reset done");
    foreach (rows[i]) begin
      w_n(rows[i].sub, '{default: rows[i].wd}, 1);
      r_n(rows[i].sub, 1);
      chk(q[0], rows[i].rd);
    end
    chk({6'h0, dev_state}, {6'h0, AICP_STATE_HIZ});
    $display("test table done");
    for (int s = 0; s < 8; s++) begin
      strap <= 3'(s);
      repeat (4) @(posedge sys_clk);
      host_u.wr({AICP_ADDR_HI, 3'(s)}, AICP_OFS_STATE, '{default: {5'h02, 3'(s)}}, 1, ok);
      chk({7'h0, ok}, {7'h0, s <= int'(AICP_STRAP_MAX)});
    end
    strap <= 3'h3;
    host_u.wr({4'hd, 3'h3}, AICP_OFS_STATE, '{default: 8'h13}, 1, ok);
    chk({7'h0, ok}, 8'h00);
    r_n(AICP_OFS_STATE, 1);
    chk(q[0], 8'h15);
    $display("test address done");
    w_n(AICP_OFS_CRC, '{default: 8'h00}, 1);
    w_n(8'h02, '{8'hab, 8'h11, 8'h00, 8'h00, 8'h00}, 2);
    c = crc8(crc8(8'h00, 8'hab), 8'h11);
    r_n(AICP_OFS_XOR, 3);
    chk(q[0], 8'h00);
    chk(q[1], c);
    chk(q[2], 8'h00);
    r_n(AICP_OFS_STATE, 1);
    chk(q[0], 8'h11);
    r_n(AICP_OFS_CRC, 1);
    chk(q[0], c);
    $display("test crc done");
    w_n(AICP_OFS_BOOK, '{default: AICP_XOR_BOOK}, 1);
    chk(book, AICP_XOR_BOOK);
    w_n(AICP_OFS_PAGE, '{default: 8'h01}, 1);
    chk(page, 8'h01);
    w_n(8'h10, '{8'h5a, 8'h0f, 8'h00, 8'h00, 8'h00}, 2);
    c = crc8(crc8(c, 8'h5a), 8'h0f);
    w_n(AICP_OFS_PAGE, '{default: 8'h00}, 1);
    r_n(AICP_OFS_XOR, 2);
    chk(q[0], 8'h55);
    chk(q[1], c);
    w_n(AICP_OFS_XOR, '{default: 8'h00}, 1);
    r_n(AICP_OFS_XOR, 1);
    chk(q[0], 8'h00);
    $display("test xor done");
    w_n(AICP_OFS_CRC, '{default: 8'h00}, 1);
    w_n(AICP_OFS_BOOK, '{default: AICP_COEF_BOOK}, 1);
    chk(book, AICP_COEF_BOOK);
    w_n(AICP_OFS_PAGE, '{default: 8'h01}, 1);
    w_n(8'h18, '{8'h01, 8'h02, 8'h03, 8'h04, 8'h05}, 5);
    w_n(AICP_OFS_PAGE, '{default: 8'h00}, 1);
    c = 8'h00;
    for (int k = 1; k < 6; k++) c = crc8(c, 8'(k));
    r_n(AICP_OFS_CRC, 1);
    chk(q[0], c);
    $display("test coefficient done");
    ce <= 1'b0;
    power_down_pin <= 1'b0;
    repeat (6) @(posedge sys_clk);
    chk(book, AICP_COEF_BOOK);
    ce <= 1'b1;
    repeat (6) @(posedge sys_clk);
    chk({6'h0, dev_state}, {6'h0, AICP_STATE_HIZ});
    chk(book, 8'h00);
    chk(page, 8'h00);
    $display("test power down done");
    finish_test();
  end
endmodule // tb
`default_nettype wire
